//--- hw/rsi_pkg.sv
/*
  Shared constants of the remote state string interpreter: command codes,
  string lengths, character classes, state and string-kind enumerations.
  Assumes command codes arrive as two ASCII characters, first one first.
*/
package rsi_pkg;

  // ----------------------------------------------------------------------
  // Command codes, two ASCII characters each.
  // ----------------------------------------------------------------------
  localparam logic [15:0] RSI_FULL_DUMP_CMD    = 16'h4F4C;
  localparam logic [15:0] RSI_FULL_LOAD_CMD    = 16'h494C;
  localparam logic [15:0] RSI_COMPACT_DUMP_CMD = 16'h4F58;
  localparam logic [15:0] RSI_COMPACT_LOAD_CMD = 16'h4958;
  localparam logic [15:0] RSI_MODE_DUMP_CMD    = 16'h4F4D;
  localparam logic [15:0] RSI_PARAM_DUMP_CMD   = 16'h4F50;
  localparam logic [15:0] RSI_ACTIVE_DUMP_CMD  = 16'h4F41;
  localparam logic [15:0] RSI_TRIGGER_CMD      = 16'h4E54;

  // ----------------------------------------------------------------------
  // Single characters of the compact load mode; all but the two terminator second characters are looked at.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RSI_TERM_FIRST_CH  = 8'h4D;
  localparam logic [7:0] RSI_TERM_ZERO_CH   = 8'h30;
  localparam logic [7:0] RSI_TERM_LETTER_CH = 8'h4F;
  localparam logic [7:0] RSI_TRIG_FIRST_CH  = 8'h4E;
  localparam logic [7:0] RSI_TRIG_SECOND_CH = 8'h54;
  localparam logic [7:0] RSI_DIGIT_LO_CH    = 8'h30;
  localparam logic [7:0] RSI_DIGIT_HI_CH    = 8'h39;
  localparam logic [7:0] RSI_HEX_LO_CH      = 8'h41;
  localparam logic [7:0] RSI_HEX_HI_CH      = 8'h46;

  // ----------------------------------------------------------------------
  // String lengths in bytes, and the last byte index of a compact load word.
  // ----------------------------------------------------------------------
  localparam logic [6:0] RSI_FULL_LEN    = 7'h5A;
  localparam logic [6:0] RSI_COMPACT_LEN = 7'h08;
  localparam logic [6:0] RSI_MODE_LEN    = 7'h08;
  localparam logic [6:0] RSI_PARAM_LEN   = 7'h04;
  localparam logic [2:0] RSI_CL_LAST     = 3'h7;

  // ----------------------------------------------------------------------
  // Enumerations.
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    RSI_S_CMD1  = 4'h0,
    RSI_S_CMD2  = 4'h1,
    RSI_S_PARAM = 4'h2,
    RSI_S_FLOAD = 4'h3,
    RSI_S_CLOAD = 4'h4,
    RSI_S_CTRIG = 4'h5,
    RSI_S_CTERM = 4'h6,
    RSI_S_DUMP  = 4'h7
  } rsi_state_t;

  typedef enum logic [1:0] {
    RSI_K_FULL    = 2'h0,
    RSI_K_COMPACT = 2'h1,
    RSI_K_MODE    = 2'h2,
    RSI_K_PARAM   = 2'h3
  } rsi_kind_t;

endpackage

//--- hw/rsi_fifo.sv
/*
  Shift-register FIFO with valid and ready on both sides; the head entry
  and the output valid are flip-flops.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D);

  logic [W-1:0]  mem_r   [D];
  logic [W-1:0]  mem_nxt [D];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] wr_idx;
  logic          vld_r;
  logic          push;
  logic          pop;

  // Handshakes; a full FIFO stalls the source.
  assign in_ready  = (cnt_r != FULL_CNT);
  assign push      = in_valid && in_ready;
  assign pop       = vld_r && out_ready;
  assign wr_idx    = pop ? cnt_r - CW'(1) : cnt_r;
  assign cnt_nxt   = cnt_r + CW'(push) - CW'(pop);
  assign out_valid = vld_r;
  assign out_data  = mem_r[0];

  // Each entry shifts down on a pop and takes new data at the tail.
  genvar g;
  generate
    for (g = 0; g < D; g++) begin : g_ent
      always_comb begin
        mem_nxt[g] = mem_r[g];
        if (pop && (g + 1 < D)) begin
          mem_nxt[g] = mem_r[(g + 1 < D) ? g + 1 : g];
        end
        if (push && (wr_idx == CW'(g))) begin
          mem_nxt[g] = in_data;
        end
      end
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          mem_r[g] <= '0;
        end else begin
          mem_r[g] <= mem_nxt[g];
        end
      end
    end
  endgenerate

  // Fill level and output valid.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      vld_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      vld_r <= (cnt_nxt != '0);
    end
  end

endmodule
`default_nettype wire

//--- hw/rsi_interp.sv
/*
  Remote state string interpreter: decodes two-character commands from the
  remote controller, emits state strings through an 8-word FIFO and loads
  full or compact snapshots into the instrument.
  Assumes the controller stream, the state store and the tx sink all run
  on sys_clk; the state store answers a read on the cycle after st_rd.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_interp
  import rsi_pkg::*;
#(
  parameter int PW = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire logic          rx_valid,
  output logic               rx_ready,
  input  wire logic [7:0]    rx_data,
  output logic               tx_valid,
  input  wire logic          tx_ready,
  output logic [7:0]         tx_data,
  output logic               st_rd,
  output logic               st_we,
  output logic [6:0]         st_addr,
  output logic [7:0]         st_wdata,
  input  wire logic [7:0]    st_rdata,
  output logic               full_restore,
  input  wire logic [63:0]   cw_snapshot,
  input  wire logic [63:0]   mode_flags,
  output logic [PW-1:0]      param_sel,
  input  wire logic [PW-1:0] active_param_idx,
  input  wire logic [31:0]   param_value,
  output logic               dac_load,
  output logic [63:0]        dac_data,
  output logic               display_blank,
  output logic               trig_pulse,
  output logic               cmd_fwd_valid,
  output logic [15:0]        cmd_fwd_code
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  rsi_state_t      state_r, state_nxt;
  rsi_kind_t       kind_r, kind_nxt;
  logic [7:0]      first_r, first_nxt;
  logic [6:0]      idx_r, idx_nxt;
  logic [1:0]      ph_r, ph_nxt;
  logic [7:0]      hold_r, hold_nxt;
  logic [2:0]      ccnt_r, ccnt_nxt;
  logic [55:0]     csh_r, csh_nxt;
  logic            rdy_r, rdy_nxt;
  logic            rd_r, rd_nxt, we_r, we_nxt, rst_r, rst_nxt;
  logic [6:0]      addr_r, addr_nxt;
  logic [7:0]      wdat_r, wdat_nxt;
  logic [PW-1:0]   psel_r, psel_nxt;
  logic            dld_r, dld_nxt, blank_r, blank_nxt;
  logic [63:0]     ddat_r, ddat_nxt;
  logic            trig_r, trig_nxt, fwd_r, fwd_nxt;
  logic [15:0]     fcode_r, fcode_nxt;
  logic            push;
  logic            fifo_in_ready;
  logic            accept;
  logic            is_hex;
  logic [15:0]     code;
  logic [6:0]      len;

  assign accept = rx_valid && rdy_r;
  assign code   = {first_r, rx_data};
  assign is_hex = ((rx_data >= RSI_DIGIT_LO_CH)
                && (rx_data <= RSI_DIGIT_HI_CH))
               || ((rx_data >= RSI_HEX_LO_CH) && (rx_data <= RSI_HEX_HI_CH));
  assign push   = (state_r == RSI_S_DUMP) && (ph_r == 2'h2) && fifo_in_ready;

  // Length of the string being dumped.
  always_comb begin
    case (kind_r)
      RSI_K_FULL:    len = RSI_FULL_LEN;
      RSI_K_COMPACT: len = RSI_COMPACT_LEN;
      RSI_K_MODE:    len = RSI_MODE_LEN;
      default:       len = RSI_PARAM_LEN;
    endcase
  end

  // ----------------------------------------------------------------------
  // Command decoder and string engine.
  // ----------------------------------------------------------------------
  // Next-state logic; pulses default low and hold values stay put.
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    first_nxt = first_r;
    idx_nxt   = idx_r;
    ph_nxt    = ph_r;
    hold_nxt  = hold_r;
    ccnt_nxt  = ccnt_r;
    csh_nxt   = csh_r;
    rd_nxt    = 1'b0;
    we_nxt    = 1'b0;
    rst_nxt   = 1'b0;
    addr_nxt  = addr_r;
    wdat_nxt  = wdat_r;
    psel_nxt  = psel_r;
    dld_nxt   = 1'b0;
    ddat_nxt  = ddat_r;
    blank_nxt = blank_r;
    trig_nxt  = 1'b0;
    fwd_nxt   = 1'b0;
    fcode_nxt = fcode_r;
    case (state_r)
      RSI_S_CMD1: begin
        if (accept) begin
          first_nxt = rx_data;
          state_nxt = RSI_S_CMD2;
        end
      end
      RSI_S_CMD2: begin
        if (accept) begin
          idx_nxt   = '0;
          ph_nxt    = 2'h0;
          state_nxt = RSI_S_DUMP;
          if (code == RSI_FULL_DUMP_CMD) begin
            kind_nxt = RSI_K_FULL;
          end else if (code == RSI_COMPACT_DUMP_CMD) begin
            kind_nxt = RSI_K_COMPACT;
          end else if (code == RSI_MODE_DUMP_CMD) begin
            kind_nxt = RSI_K_MODE;
          end else if (code == RSI_ACTIVE_DUMP_CMD) begin
            kind_nxt = RSI_K_PARAM;
            psel_nxt = active_param_idx;
          end else if (code == RSI_PARAM_DUMP_CMD) begin
            state_nxt = RSI_S_PARAM;
          end else if (code == RSI_FULL_LOAD_CMD) begin
            state_nxt = RSI_S_FLOAD;
          end else if (code == RSI_COMPACT_LOAD_CMD) begin
            blank_nxt = 1'b1;
            ccnt_nxt  = '0;
            state_nxt = RSI_S_CLOAD;
          end else if (code == RSI_TRIGGER_CMD) begin
            trig_nxt  = 1'b1;
            state_nxt = RSI_S_CMD1;
          end else begin
            // Any other code goes to the instrument and restores displays.
            fwd_nxt   = 1'b1;
            fcode_nxt = code;
            blank_nxt = 1'b0;
            state_nxt = RSI_S_CMD1;
          end
        end
      end
      RSI_S_PARAM: begin
        if (accept) begin
          psel_nxt  = rx_data[PW-1:0];
          kind_nxt  = RSI_K_PARAM;
          state_nxt = RSI_S_DUMP;
        end
      end
      RSI_S_FLOAD: begin
        if (accept) begin
          we_nxt   = 1'b1;
          addr_nxt = idx_r;
          wdat_nxt = rx_data;
          if (idx_r == RSI_FULL_LEN - 7'h01) begin
            rst_nxt   = 1'b1;
            state_nxt = RSI_S_CMD1;
          end else begin
            idx_nxt = idx_r + 7'h01;
          end
        end
      end
      RSI_S_CLOAD: begin
        if (accept) begin
          if (is_hex) begin
            csh_nxt = {csh_r[47:0], rx_data};
            if (ccnt_r == RSI_CL_LAST) begin
              dld_nxt  = 1'b1;
              ddat_nxt = {csh_r, rx_data};
              ccnt_nxt = '0;
            end else begin
              ccnt_nxt = ccnt_r + 3'h1;
            end
          end else if (rx_data == RSI_TRIG_FIRST_CH) begin
            state_nxt = RSI_S_CTRIG;
          end else if (rx_data == RSI_TERM_FIRST_CH) begin
            state_nxt = RSI_S_CTERM;
          end else begin
            // Leaving the mode; the byte opens a normal code.
            first_nxt = rx_data;
            state_nxt = RSI_S_CMD2;
          end
        end
      end
      RSI_S_CTRIG: begin
        if (accept) begin
          if (rx_data == RSI_TRIG_SECOND_CH) begin
            trig_nxt  = 1'b1;
            state_nxt = RSI_S_CLOAD;
          end else begin
            state_nxt = RSI_S_CMD1;
          end
        end
      end
      RSI_S_CTERM: begin
        // Terminator second character is the digit or the letter; both end
        // the mode, and displays stay blank until a normal code arrives.
        if (accept) begin
          state_nxt = RSI_S_CMD1;
        end
      end
      RSI_S_DUMP: begin
        case (ph_r)
          2'h0: begin
            rd_nxt   = (kind_r == RSI_K_FULL);
            addr_nxt = idx_r;
            ph_nxt   = 2'h1;
          end
          2'h1: begin
            ph_nxt = 2'h2;
            case (kind_r)
              RSI_K_FULL:    ph_nxt   = 2'h3;
              RSI_K_COMPACT: hold_nxt = cw_snapshot[8*(7-idx_r[2:0]) +: 8];
              RSI_K_MODE:    hold_nxt = mode_flags[8*(7-idx_r[2:0]) +: 8];
              default:       hold_nxt = param_value[8*(3-idx_r[1:0]) +: 8];
            endcase
          end
          2'h3: begin
            // The store answers only in the cycle after the read strobe.
            hold_nxt = st_rdata;
            ph_nxt   = 2'h2;
          end
          default: begin
            if (push) begin
              ph_nxt = 2'h0;
              if (idx_r == len - 7'h01) begin
                state_nxt = RSI_S_CMD1;
              end else begin
                idx_nxt = idx_r + 7'h01;
              end
            end
          end
        endcase
      end
      default: state_nxt = RSI_S_CMD1;
    endcase
    rdy_nxt = (state_nxt != RSI_S_DUMP);
  end

  // Registers of the decoder and string engine.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= RSI_S_CMD1;
      kind_r  <= RSI_K_FULL;
      first_r <= '0;
      idx_r   <= '0;
      ph_r    <= '0;
      hold_r  <= '0;
      ccnt_r  <= '0;
      csh_r   <= '0;
      rdy_r   <= 1'b0;
      rd_r    <= 1'b0;
      we_r    <= 1'b0;
      rst_r   <= 1'b0;
      addr_r  <= '0;
      wdat_r  <= '0;
      psel_r  <= '0;
      dld_r   <= 1'b0;
      ddat_r  <= '0;
      blank_r <= 1'b0;
      trig_r  <= 1'b0;
      fwd_r   <= 1'b0;
      fcode_r <= '0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      first_r <= first_nxt;
      idx_r   <= idx_nxt;
      ph_r    <= ph_nxt;
      hold_r  <= hold_nxt;
      ccnt_r  <= ccnt_nxt;
      csh_r   <= csh_nxt;
      rdy_r   <= rdy_nxt;
      rd_r    <= rd_nxt;
      we_r    <= we_nxt;
      rst_r   <= rst_nxt;
      addr_r  <= addr_nxt;
      wdat_r  <= wdat_nxt;
      psel_r  <= psel_nxt;
      dld_r   <= dld_nxt;
      ddat_r  <= ddat_nxt;
      blank_r <= blank_nxt;
      trig_r  <= trig_nxt;
      fwd_r   <= fwd_nxt;
      fcode_r <= fcode_nxt;
    end
  end

  // Outputs straight from the registers above.
  assign rx_ready      = rdy_r;
  assign st_rd         = rd_r;
  assign st_we         = we_r;
  assign st_addr       = addr_r;
  assign st_wdata      = wdat_r;
  assign full_restore  = rst_r;
  assign param_sel     = psel_r;
  assign dac_load      = dld_r;
  assign dac_data      = ddat_r;
  assign display_blank = blank_r;
  assign trig_pulse    = trig_r;
  assign cmd_fwd_valid = fwd_r;
  assign cmd_fwd_code  = fcode_r;

  // ----------------------------------------------------------------------
  // Transmit FIFO; a stalled sink holds the string engine in phase two.
  // ----------------------------------------------------------------------
  rsi_fifo #(.W(8), .D(8)) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (hold_r),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  // Counts pushes of the current dump and writes of the current full load.
  logic [6:0] pcnt_q, wcnt_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pcnt_q <= '0;
      wcnt_q <= '0;
    end else begin
      pcnt_q <= (state_r != RSI_S_DUMP) ? 7'h00 : pcnt_q + 7'(push);
      wcnt_q <= rst_r ? 7'h00 : wcnt_q + 7'(we_r);
    end
  end

  property p_full_len;
    @(posedge sys_clk) disable iff (!resetn)
    (push && state_nxt == RSI_S_CMD1 && kind_r == RSI_K_FULL)
      |-> (pcnt_q == RSI_FULL_LEN - 7'h01);
  endproperty
  a_full_len: assert property (p_full_len)
    else $error("Full dump length is not ninety.");

  property p_cw_len;
    @(posedge sys_clk) disable iff (!resetn)
    (push && state_nxt == RSI_S_CMD1 && kind_r != RSI_K_FULL)
      |-> (pcnt_q == len - 7'h01) && (len <= RSI_MODE_LEN);
  endproperty
  a_cw_len: assert property (p_cw_len)
    else $error("Short dump length is wrong.");

  property p_restore;
    @(posedge sys_clk) disable iff (!resetn)
    full_restore |-> we_r && (wcnt_q == RSI_FULL_LEN - 7'h01);
  endproperty
  a_restore: assert property (p_restore)
    else $error("Restore without a complete full snapshot.");

  property p_blank;
    @(posedge sys_clk) disable iff (!resetn)
    (state_r == RSI_S_CLOAD) |-> display_blank;
  endproperty
  a_blank: assert property (p_blank)
    else $error("Displays not blanked in compact load.");

  property p_hex_stays;
    @(posedge sys_clk) disable iff (!resetn)
    (state_r == RSI_S_CLOAD && accept && is_hex) |=> state_r == RSI_S_CLOAD;
  endproperty
  a_hex_stays: assert property (p_hex_stays)
    else $error("Hex data left compact load.");

  property p_trig;
    @(posedge sys_clk) disable iff (!resetn)
    (state_r == RSI_S_CTRIG && accept && rx_data == RSI_TRIG_SECOND_CH)
      |=> trig_pulse && state_r == RSI_S_CLOAD ##1 !trig_pulse;
  endproperty
  a_trig: assert property (p_trig)
    else $error("Trigger not executed in compact load.");

  property p_dac;
    @(posedge sys_clk) disable iff (!resetn)
    dac_load |-> $past(state_r) == RSI_S_CLOAD && $past(ccnt_r) == RSI_CL_LAST;
  endproperty
  a_dac: assert property (p_dac)
    else $error("Converter preload before eight bytes.");

  property p_active;
    @(posedge sys_clk) disable iff (!resetn)
    (state_r == RSI_S_CMD2 && accept && code == RSI_ACTIVE_DUMP_CMD)
      |=> param_sel == $past(active_param_idx) && kind_r == RSI_K_PARAM;
  endproperty
  a_active: assert property (p_active)
    else $error("Active parameter not selected.");

  property p_named;
    @(posedge sys_clk) disable iff (!resetn)
    (state_r == RSI_S_PARAM && accept)
      |=> param_sel == $past(rx_data[PW-1:0]) ##[1:3] (ph_r == 2'h2);
  endproperty
  a_named: assert property (p_named)
    else $error("Named parameter not selected.");

endmodule
`default_nettype wire

//--- testbench/rsi_partner.sv
/*
  Far-side model: the state store that answers a read on the next cycle,
  and the tx sink whose ready follows a stall request.
  Assumes the interpreter and the bench run on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_partner (
  input  wire logic       sys_clk,
  input  wire logic       stall,
  input  wire logic       st_rd,
  input  wire logic       st_we,
  input  wire logic [6:0] st_addr,
  input  wire logic [7:0] st_wdata,
  output logic [7:0]      st_rdata,
  output logic            tx_ready
);
  logic [7:0] mem [0:127];

  initial st_rdata = 8'h00;

  // Writes stage a snapshot; a read answers next cycle, else the bus flips.
  always @(posedge sys_clk) begin
    if (st_we) mem[st_addr] <= st_wdata;
    st_rdata <= st_rd ? mem[st_addr] : ~st_rdata;
  end

  // The sink refuses bytes whenever a stall is asked for.
  assign tx_ready = !stall;
endmodule
`default_nettype wire

//--- testbench/tb_rsi_interp.sv
/*
  Self-checking bench of the interpreter with a queue model of each string.
  Assumes the partner model stands for the state store and the tx sink.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_rsi_interp;
  import rsi_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, rx_valid = 1'b0, stall = 1'b0;
  logic rx_ready, tx_valid, tx_ready, st_rd, st_we, full_restore, took;
  logic dac_load, display_blank, trig_pulse, cmd_fwd_valid, hold_all;
  logic [7:0]  rx_data, tx_data, st_wdata, st_rdata, b, param_sel, idx;
  logic [7:0]  active_param_idx;
  logic [6:0]  st_addr;
  logic [15:0] cmd_fwd_code, last_fwd, lfsr_r = 16'h46BA;
  logic [31:0] param_value;
  logic [63:0] cw_snapshot, mode_flags, dac_data, last_dac, exp64;
  logic [7:0]  exp_q [$];
  int err_count = 0, n_tests = 0, n_got, n_we = 0, n_fr = 0;
  int n_dac = 0, n_trig = 0, n_fwd = 0;

  rsi_interp #(.PW(8)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .st_rd(st_rd), .st_we(st_we),
    .st_addr(st_addr), .st_wdata(st_wdata), .st_rdata(st_rdata),
    .full_restore(full_restore), .cw_snapshot(cw_snapshot),
    .mode_flags(mode_flags), .param_sel(param_sel),
    .active_param_idx(active_param_idx), .param_value(param_value),
    .dac_load(dac_load), .dac_data(dac_data),
    .display_blank(display_blank), .trig_pulse(trig_pulse),
    .cmd_fwd_valid(cmd_fwd_valid), .cmd_fwd_code(cmd_fwd_code));

  rsi_partner u_far (
    .sys_clk(sys_clk), .stall(stall), .st_rd(st_rd), .st_we(st_we),
    .st_addr(st_addr), .st_wdata(st_wdata), .st_rdata(st_rdata),
    .tx_ready(tx_ready));

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;

  function automatic logic [7:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r[7:0];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // A byte is held until the edge at which the interpreter takes it.
  task automatic send(input logic [7:0] v);
    rx_data = v;
    rx_valid = 1'b1;
    do tick(1); while (!took);
  endtask

  task automatic req(input logic [15:0] c);
    n_got = 0;
    send(c[15:8]);
    send(c[7:0]);
  endtask

  task automatic drain();
    rx_valid = 1'b0;
    for (int i = 0; i < 1000; i++) begin
      if (exp_q.size() == 0 && rx_ready === 1'b1) break;
      tick(1);
    end
    tick(3);
  endtask

  // The take flag samples the handshake as the edge sees it.
  always @(posedge sys_clk) took <= rx_valid && rx_ready;

  // The sink stalls at random, or throughout while asked to hold.
  always @(posedge sys_clk) begin
    #1;
    stall = hold_all | ^rnd();
  end

  // Every string byte and every pulse but st_rd is looked at mid-cycle.
  always @(negedge sys_clk) if (resetn) begin
    if (tx_valid && tx_ready) begin
      n_got++;
      check(tx_data, exp_q.pop_front());
    end
    if (st_we) n_we++;
    if (full_restore) begin
      n_fr++;
      check({st_we, st_addr}, 8'hD9);
    end
    if (dac_load) begin
      n_dac++;
      last_dac = dac_data;
    end
    if (trig_pulse) n_trig++;
    if (cmd_fwd_valid) begin
      n_fwd++;
      last_fwd = cmd_fwd_code;
    end
  end

  // The watchdog cuts a hang short.
  initial begin
    #2000000;
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    {cw_snapshot, mode_flags, param_value, active_param_idx} = '0;
    rx_data = 8'h00;
    hold_all = 1'b0;
    tick(4);
    check({rx_ready, tx_valid, display_blank, dac_load}, 4'h0);
    resetn = 1'b1;
    tick(2);
    // A full snapshot written back comes out again whole.
    req(RSI_FULL_LOAD_CMD);
    repeat (90) begin
      b = rnd();
      exp_q.push_back(b);
      send(b);
    end
    rx_valid = 1'b0;
    tick(4);
    check(n_we, 90);
    check(n_fr, 1);
    req(RSI_FULL_DUMP_CMD);
    drain();
    check(n_got, 90);
    // The first 8-byte string fills the FIFO and the second stalls the engine while the sink holds off.
    for (int i = 0; i < 8; i++) begin
      cw_snapshot = {cw_snapshot[55:0], rnd()};
    end
    for (int i = 0; i < 8; i++) mode_flags = {mode_flags[55:0], rnd()};
    for (int i = 0; i < 8; i++) exp_q.push_back(cw_snapshot[63-8*i -: 8]);
    for (int i = 0; i < 8; i++) exp_q.push_back(mode_flags[63-8*i -: 8]);
    hold_all = 1'b1;
    tick(2);
    req(RSI_COMPACT_DUMP_CMD);
    rx_valid = 1'b0;
    tick(40);
    send(RSI_MODE_DUMP_CMD[15:8]);
    send(RSI_MODE_DUMP_CMD[7:0]);
    rx_valid = 1'b0;
    tick(40);
    check(rx_ready, 1'b0);
    check(exp_q.size(), 16);
    hold_all = 1'b0;
    drain();
    check(n_got, 16);
    // Named and active parameter readback.
    for (int k = 0; k < 3; k++) begin
      idx = rnd();
      active_param_idx = rnd();
      param_value = {rnd(), rnd(), rnd(), rnd()};
      for (int i = 0; i < 4; i++) exp_q.push_back(param_value[31-8*i -: 8]);
      req(RSI_PARAM_DUMP_CMD);
      send(idx);
      drain();
      check({n_got, param_sel}, {32'h4, idx});
      for (int i = 0; i < 4; i++) exp_q.push_back(param_value[31-8*i -: 8]);
      req(RSI_ACTIVE_DUMP_CMD);
      drain();
      check({n_got, param_sel}, {32'h4, active_param_idx});
    end
    // Compact load: 8 data bytes, a trigger, a partial string, terminator.
    req(RSI_COMPACT_LOAD_CMD);
    rx_valid = 1'b0;
    tick(2);
    check(display_blank, 1'b1);
    for (int i = 0; i < 8; i++) begin
      b = rnd() % 16;
      b = (b < 10) ? b + 8'h30 : b + 8'h37;
      exp64 = {exp64[55:0], b};
      if (i == 7) begin
        rx_valid = 1'b0;
        tick(3);
        check(n_dac, 0);
      end
      send(b);
    end
    send(RSI_TRIG_FIRST_CH);
    send(RSI_TRIG_SECOND_CH);
    foreach (exp_q[i]) send(8'h00);
    send(8'h30);
    send(8'h39);
    send(8'h41);
    send(8'h46);
    send(RSI_TERM_FIRST_CH);
    send(RSI_TERM_ZERO_CH);
    rx_valid = 1'b0;
    tick(4);
    check({n_dac, last_dac}, {32'h1, exp64});
    check({n_trig, n_fwd}, {32'h1, 32'h0});
    check(display_blank, 1'b1);
    req(16'h4357);
    rx_valid = 1'b0;
    tick(4);
    check({n_fwd, last_fwd, display_blank}, {32'h1, 16'h4357, 1'b0});
    // A byte just past F leaves the mode and starts a normal code.
    req(RSI_COMPACT_LOAD_CMD);
    send(8'h46);
    send(8'h47);
    send(8'h51);
    rx_valid = 1'b0;
    tick(4);
    check({n_fwd, last_fwd, n_dac}, {32'h2, 16'h4751, 32'h1});
    report_and_stop();
  end
endmodule
`default_nettype wire
